// ### design/tls_regs.v
// Contract
// R1: All selects zero plus global bit: strict priority
// R2: Selects one: weighted 8:4:2:1 or 2:1
// R3: Select bit resets 1; low bits fixed weights
// R4: Enable register gates each status bit
// R5: Host enables, clears, then waits interrupt
// R6: Write one clears status; zero keeps
// R7: Copper port 1 or 2 change sets bit7
// R8: Port 3 link change sets bit2
// R9: Port 2 link change sets bit1
// R10: Port 1 change sets bit0; 6-3 zero
// R11: Limit enable: 160 ms forced pause timeout
// R12: Interrupt low while enabled status pending
// R13: Enable, status, pause registers reset zero
`timescale 1ns/1ps
`include "tls_map.vh"

module tls_regs #(
    parameter integer PAUSE_LIMIT_CYCLES = `TLS_PAUSE_LIMIT_MS * `TLS_CLK_KHZ
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       global_prio_scheme,
    input  wire       two_queue_mode,
    input  wire       p1_link_change,
    input  wire       p2_link_change,
    input  wire       p3_link_change,
    input  wire       forced_pause_active,
    output reg  [1:0] sched_mode,
    output reg  [3:0] transmit_queue_weighting,
    output reg        pause_invalidate_req,
    output reg        irq_out_n
);

    // ****************************************
    // Register state
    // ****************************************
    reg  [3:0]  sel;
    reg  [7:0]  irq_enable;
    reg  [7:0]  link_change_flag;
    reg  [7:0]  pause_limit_enable;
    reg  [31:0] pause_count;

    // ****************************************
    // Next values
    // ****************************************
    reg  [3:0]  next_sel;
    reg  [7:0]  next_enable;
    reg  [7:0]  next_pause_en;
    reg  [7:0]  next_flag;
    reg  [7:0]  set_mask;
    reg  [7:0]  clr_mask;
    reg  [7:0]  next_rdata;
    reg  [1:0]  next_mode;
    reg  [31:0] next_count;
    reg         next_req;

    localparam [1:0]  MODE_STRICT = 2'h0;
    localparam [1:0]  MODE_W8421  = 2'h1;
    localparam [1:0]  MODE_W21    = 2'h2;
    localparam [1:0]  MODE_MIXED  = 2'h3;
    // Last count before the request; a short limit keeps simulation brief
    localparam [31:0] LIMIT_LAST  = PAUSE_LIMIT_CYCLES - 1;

    // ****************************************
    // Write decode
    // ****************************************
    wire        wr_q3;
    wire        wr_q2;
    wire        wr_q1;
    wire        wr_q0;
    wire        wr_enable;
    wire        wr_status;
    wire        wr_pause;

    assign wr_q3     = reg_wr && (reg_addr == `TLS_OFF_Q3_SEL);
    assign wr_q2     = reg_wr && (reg_addr == `TLS_OFF_Q2_SEL);
    assign wr_q1     = reg_wr && (reg_addr == `TLS_OFF_Q1_SEL);
    assign wr_q0     = reg_wr && (reg_addr == `TLS_OFF_Q0_SEL);
    assign wr_enable = reg_wr && (reg_addr == `TLS_OFF_IRQ_EN);
    assign wr_status = reg_wr && (reg_addr == `TLS_OFF_IRQ_STAT);
    assign wr_pause  = reg_wr && (reg_addr == `TLS_OFF_PAUSE_EN);

    // ****************************************
    // Select bits
    // ****************************************
    // Only bit 7 is stored; the low weights are constants and ignore writes
    always @* begin
        next_sel = sel;
        if (wr_q3) begin
            next_sel[3] = reg_wdata[`TLS_SEL_BIT]; // R3
        end
        if (wr_q2) begin
            next_sel[2] = reg_wdata[`TLS_SEL_BIT]; // R3
        end
        if (wr_q1) begin
            next_sel[1] = reg_wdata[`TLS_SEL_BIT]; // R3
        end
        if (wr_q0) begin
            next_sel[0] = reg_wdata[`TLS_SEL_BIT]; // R3
        end
    end

    // ****************************************
    // Scheduling mode
    // ****************************************
    // Mixed selects are no defined scheme; the scheduler decides how to treat them
    always @* begin
        if (sel == 4'h0 && !global_prio_scheme) begin
            next_mode = MODE_STRICT; // R1
        end else if (sel == 4'hf) begin
            next_mode = two_queue_mode ? MODE_W21 : MODE_W8421; // R2
        end else begin
            next_mode = MODE_MIXED;
        end
    end

    // ****************************************
    // Enables
    // ****************************************
    always @* begin
        next_enable   = wr_enable ? reg_wdata : irq_enable; // R4
        next_pause_en = wr_pause ? reg_wdata : pause_limit_enable; // R11
    end

    // ****************************************
    // Status update, set beats clear
    // ****************************************
    always @* begin
        set_mask                    = 8'h00;
        set_mask[`TLS_LINK_P12_BIT] = p1_link_change | p2_link_change; // R7
        set_mask[`TLS_LINK_P3_BIT]  = p3_link_change; // R8
        set_mask[`TLS_LINK_P2_BIT]  = p2_link_change; // R9
        set_mask[`TLS_LINK_P1_BIT]  = p1_link_change; // R10
        clr_mask                    = wr_status ? reg_wdata : 8'h00; // R6
        // An event in the clearing cycle must never be lost
        next_flag = ((link_change_flag & ~clr_mask) | set_mask) & `TLS_LINK_IMPL_MASK; // R10
    end

    // ****************************************
    // Pause limit
    // ****************************************
    // Any nonzero value enables the limit; the count restarts when pause lifts
    always @* begin
        next_count = pause_count;
        next_req   = pause_invalidate_req;
        if (pause_limit_enable == 8'h00 || !forced_pause_active) begin
            next_count = 32'h0000_0000; // R11
            next_req   = 1'b0;
        end else if (pause_count >= LIMIT_LAST) begin
            next_req   = 1'b1; // R11
        end else begin
            next_count = pause_count + 32'h0000_0001;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @* begin
        case (reg_addr)
            `TLS_OFF_Q3_SEL:   next_rdata = {sel[3], `TLS_Q3_WEIGHT}; // R3
            `TLS_OFF_Q2_SEL:   next_rdata = {sel[2], `TLS_Q2_WEIGHT}; // R3
            `TLS_OFF_Q1_SEL:   next_rdata = {sel[1], `TLS_Q1_WEIGHT}; // R3
            `TLS_OFF_Q0_SEL:   next_rdata = {sel[0], `TLS_Q0_WEIGHT}; // R3
            `TLS_OFF_IRQ_EN:   next_rdata = irq_enable;
            `TLS_OFF_IRQ_STAT: next_rdata = link_change_flag;
            `TLS_OFF_PAUSE_EN: next_rdata = pause_limit_enable;
            default:           next_rdata = 8'h00;
        endcase
    end

    // ****************************************
    // Select registers and scheduler outputs
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel                      <= {4{`TLS_SEL_RST}}; // R3
            sched_mode               <= MODE_W8421;
            transmit_queue_weighting <= 4'hf;
        end else if (ce) begin
            sel                      <= next_sel;
            sched_mode               <= next_mode;
            transmit_queue_weighting <= sel;
        end
    end

    // ****************************************
    // Interrupt registers
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable       <= `TLS_REG_RST; // R13
            link_change_flag <= `TLS_REG_RST; // R13
            irq_out_n        <= 1'b1;
        end else if (ce) begin
            irq_enable       <= next_enable; // R4
            link_change_flag <= next_flag;
            // Uses the new mask and flags so a write acts on the pin at once
            irq_out_n        <= ~|(next_flag & next_enable); // R4 R12
        end
    end

    // ****************************************
    // Pause registers
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pause_limit_enable   <= `TLS_REG_RST; // R13
            pause_count          <= 32'h0000_0000;
            pause_invalidate_req <= 1'b0;
        end else if (ce) begin
            pause_limit_enable   <= next_pause_en;
            pause_count          <= next_count;
            pause_invalidate_req <= next_req; // R11
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Held until the next read so a slow host can sample at leisure
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule

// ### design/tls_map.vh
`ifndef TLS_MAP_VH
`define TLS_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define TLS_OFF_Q3_SEL      8'hb7
`define TLS_OFF_Q2_SEL      8'hb8
`define TLS_OFF_Q1_SEL      8'hb9
`define TLS_OFF_Q0_SEL      8'hba
`define TLS_OFF_IRQ_EN      8'hbb
`define TLS_OFF_IRQ_STAT    8'hbc
`define TLS_OFF_PAUSE_EN    8'hbd
// ****************************************
// Fields and reset values
// ****************************************
`define TLS_SEL_BIT         7
`define TLS_SEL_RST         1'b1
`define TLS_Q3_WEIGHT       7'h08
`define TLS_Q2_WEIGHT       7'h04
`define TLS_Q1_WEIGHT       7'h02
`define TLS_Q0_WEIGHT       7'h01
`define TLS_LINK_P12_BIT    7
`define TLS_LINK_P3_BIT     2
`define TLS_LINK_P2_BIT     1
`define TLS_LINK_P1_BIT     0
`define TLS_LINK_IMPL_MASK  8'h87
`define TLS_REG_RST         8'h00
// ****************************************
// Timing
// ****************************************
`define TLS_PAUSE_LIMIT_MS  160
`define TLS_CLK_KHZ         40000
`endif

// ### test/tls_regs_checker.sv
`timescale 1ns/1ps
// ****
// Port checks; the pause wait assumes a limit of at least 16 cycles
// ****
module tls_regs_checker (
    input wire       clk, rst, ce, reg_wr, p1_link_change, p2_link_change, p3_link_change,
    input wire       global_prio_scheme, two_queue_mode, forced_pause_active,
    input wire [7:0] reg_addr, reg_wdata,
    input wire [1:0] sched_mode,
    input wire [3:0] transmit_queue_weighting,
    input wire       pause_invalidate_req, irq_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire cause = p1_link_change | p2_link_change | p3_link_change;
    a_strict_order: assert property ($past(ce) && !$past(rst) && transmit_queue_weighting == 4'h0
        && !$past(global_prio_scheme) |-> sched_mode == 2'h0) else $error("strict mode missing");
    a_weighted_four: assert property ($past(ce) && !$past(rst) && transmit_queue_weighting == 4'hf
        && !$past(two_queue_mode) |-> sched_mode == 2'h1) else $error("8421 mode missing");
    a_weighted_two: assert property ($past(ce) && !$past(rst) && transmit_queue_weighting == 4'hf
        && $past(two_queue_mode) |-> sched_mode == 2'h2) else $error("21 mode missing");
    a_irq_holds_low: assert property (ce && !irq_out_n && !reg_wr |=> !irq_out_n)
        else $error("irq released without write");
    a_irq_needs_cause: assert property (ce && irq_out_n && !cause && !reg_wr |=> irq_out_n)
        else $error("irq without cause");
    a_zero_write_keeps: assert property (ce && reg_wr && reg_addr == 8'hbc && reg_wdata == 8'h00
        && !irq_out_n |=> !irq_out_n) else $error("zero write cleared");
    a_pause_drops: assert property (ce && !forced_pause_active |=> !pause_invalidate_req)
        else $error("pause request stuck");
    a_pause_waits: assert property ($rose(pause_invalidate_req) |-> $past(forced_pause_active)
        && $past(forced_pause_active, 16)) else $error("pause request early");
endmodule
bind tls_regs tls_regs_checker chk_u (.clk, .rst, .ce, .reg_wr, .p1_link_change, .p2_link_change,
    .p3_link_change, .global_prio_scheme, .two_queue_mode, .forced_pause_active, .reg_addr,
    .reg_wdata, .sched_mode, .transmit_queue_weighting, .pause_invalidate_req, .irq_out_n);

// ### test/tb_tls_regs.sv
`timescale 1ns/1ps
// ****
// Bench; short pause limit keeps the run brief
// ****
module tb_tls_regs;
    reg        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, gp = 1'b0, tq = 1'b0, fp = 1'b0;
    reg        ce = 1'b1;
    reg  [2:0] ev = 3'h0;
    reg  [7:0] addr = 8'h00, wd = 8'h00;
    wire [7:0] rdata;
    wire [1:0] mode;
    wire [3:0] wt;
    wire       req, irq_n;
    integer    bad_count = 0, checks_done = 0, i;
    tls_regs #(.PAUSE_LIMIT_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(wd), .reg_rdata(rdata),
        .global_prio_scheme(gp), .two_queue_mode(tq), .p1_link_change(ev[0]),
        .p2_link_change(ev[1]), .p3_link_change(ev[2]), .forced_pause_active(fp),
        .sched_mode(mode), .transmit_queue_weighting(wt), .pause_invalidate_req(req),
        .irq_out_n(irq_n));
    initial forever #12.5 clk = ~clk;
    task chk(input [7:0] s, input [7:0] e); begin
        checks_done = checks_done + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    end endtask
    task cy(input integer n); repeat (n) @(negedge clk); endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(negedge clk); addr = a; wd = d; reg_wr = 1'b1;
        @(negedge clk); reg_wr = 1'b0;
    end endtask
    task rc(input [7:0] a, input [7:0] e); begin
        @(negedge clk); addr = a; reg_rd = 1'b1;
        @(negedge clk); reg_rd = 1'b0;
        chk(rdata, e);
    end endtask
    task pl(input [2:0] v); begin
        @(negedge clk); ev = v;
        @(negedge clk); ev = 3'h0;
    end endtask
    task t_reset; begin
        for (i = 0; i < 4; i = i + 1) rc(8'hb7 + i, 8'h80 | (8'h08 >> i));
        for (i = 0; i < 3; i = i + 1) rc(8'hbb + i, 8'h00);
        chk(mode, 8'h01);
        chk(irq_n, 8'h01);
    end endtask
    task t_sched; begin
        for (i = 0; i < 4; i = i + 1) wr(8'hb7 + i, 8'h7f);
        for (i = 0; i < 4; i = i + 1) rc(8'hb7 + i, 8'h08 >> i);
        chk(mode, 8'h00);
        for (i = 0; i < 4; i = i + 1) wr(8'hb7 + i, 8'h80);
        tq = 1'b1; cy(2); chk(mode, 8'h02);
        tq = 1'b0; cy(2); chk(mode, 8'h01);
    end endtask
    task t_irq; begin
        wr(8'hbb, 8'h02); wr(8'hbc, 8'hff);
        pl(3'h1); chk(irq_n, 8'h01);
        rc(8'hbc, 8'h81);
        pl(3'h2); chk(irq_n, 8'h00);
        rc(8'hbc, 8'h83);
        pl(3'h4); wr(8'hbc, 8'h00); rc(8'hbc, 8'h87);
        wr(8'hbc, 8'h02); chk(irq_n, 8'h01);
        wr(8'hbc, 8'h85); rc(8'hbc, 8'h00);
        wr(8'hc0, 8'h5a); rc(8'hc0, 8'h00);
    end endtask
    task t_hold; begin
        @(negedge clk); ev = 3'h4; addr = 8'hbc; wd = 8'h04; reg_wr = 1'b1;
        @(negedge clk); ev = 3'h0; reg_wr = 1'b0;
        rc(8'hbc, 8'h04);
        wr(8'hbb, 8'h04); chk(irq_n, 8'h00);
        wr(8'hbb, 8'h00); chk(irq_n, 8'h01);
        ce = 1'b0; pl(3'h1); wr(8'hbc, 8'hff); ce = 1'b1;
        rc(8'hbc, 8'h04);
        wr(8'hbc, 8'h04); rc(8'hbc, 8'h00);
    end endtask
    task t_pause; begin
        wr(8'hbd, 8'h01); fp = 1'b1; cy(12); chk(req, 8'h00);
        cy(12); chk(req, 8'h01);
        fp = 1'b0; cy(2); chk(req, 8'h00);
        wr(8'hbd, 8'h00); fp = 1'b1; cy(40); chk(req, 8'h00);
        fp = 1'b0; rc(8'hbd, 8'h00);
    end endtask
    task complete_run; begin
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    end endtask
    initial begin
        cy(10); rst = 1'b0;
        t_reset; t_sched; t_irq; t_hold; t_pause;
        complete_run;
    end
    initial begin #50000; bad_count = bad_count + 1; complete_run; end
endmodule
